// ### logic/ifms_pkg.sv
// Purpose: shared constants and types for the i2c firmware master support block
// Assumes: registers sit one per 32-bit word, byte address = 4 * index
// Notes:   state of the top module, apart from pin_lo_r, travels as one packed struct
package ifms_pkg;

   localparam int ADDR_W = 10;
   localparam int IDX_W  = ADDR_W - 2;

   // register indices
   localparam logic [7:0] IDX_GIC = 8'h0b;
   localparam logic [7:0] IDX_PIF = 8'h0c;
   localparam logic [7:0] IDX_BUF = 8'h13;
   localparam logic [7:0] IDX_CTL = 8'h14;
   localparam logic [7:0] IDX_DIR = 8'h87;
   localparam logic [7:0] IDX_PEN = 8'h8c;
   localparam logic [7:0] IDX_ADM = 8'h93;
   localparam logic [7:0] IDX_STA = 8'h94;
   localparam logic [7:0] IDX_EVS = 8'ha0;
   localparam logic [7:0] IDX_EVC = 8'ha1;
   localparam logic [7:0] IDX_EVE = 8'ha2;

   // field positions
   localparam int GIC_GIE  = 7;
   localparam int GIC_PEIE = 6;
   localparam int PIF_SSP  = 3;
   localparam int CTL_OV   = 6;
   localparam int CTL_EN   = 5;
   localparam int DIR_SDA  = 4;
   localparam int DIR_SCL  = 3;
   localparam int EV_START = 0;
   localparam int EV_STOP  = 1;
   localparam int EV_BYTE  = 2;

   // reset values
   localparam logic [7:0] RST_DIR  = 8'hff;
   localparam logic [7:0] RST_ZERO = 8'h00;
   localparam logic       PIN_IDLE = 1'b1;

   // mode field codes
   localparam logic [3:0] MODE_S7   = 4'h6;
   localparam logic [3:0] MODE_S10  = 4'h7;
   localparam logic [3:0] MODE_MST  = 4'hb;
   localparam logic [3:0] MODE_S7I  = 4'he;
   localparam logic [3:0] MODE_S10I = 4'hf;

   localparam logic [3:0] BITS_PER_BYTE = 4'h8;
   localparam logic [1:0] RESP_OKAY     = 2'h0;
   localparam logic [1:0] RESP_SLVERR   = 2'h2;

   typedef enum logic [1:0] {PH_IDLE, PH_DATA, PH_ACK} ifms_phase_t;

   typedef struct packed {
      logic        awready;
      logic        wready;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        arready;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
      logic        awh;
      logic [7:0]  awa;
      logic        wh;
      logic [7:0]  wd;
      logic        ws;
      logic [7:0]  gic;
      logic [7:0]  pif;
      logic [7:0]  buf_q;
      logic [7:0]  ctl;
      logic [7:0]  dir;
      logic [7:0]  pen;
      logic [7:0]  adm;
      logic [1:0]  sta_hi;
      logic        s;
      logic        p;
      logic        da;
      logic        rw;
      logic        bf;
      logic [2:0]  evs;
      logic [2:0]  eve;
      ifms_phase_t ph;
      logic [3:0]  cnt;
      logic [7:0]  sr;
      logic        first;
      logic        addr;
      logic        ack;
      logic        scl_p;
      logic        sda_p;
      logic        scl_oe;
      logic        sda_oe;
      logic        irq;
   } ifms_st_t;

   localparam ifms_st_t ST_RST = '{dir: RST_DIR, ph: PH_IDLE, scl_p: PIN_IDLE,
                                   sda_p: PIN_IDLE, default: '0};

   function automatic logic ifms_mapped(input logic [7:0] i);
      return (i == IDX_GIC) || (i == IDX_PIF) || (i == IDX_BUF) || (i == IDX_CTL) ||
             (i == IDX_DIR) || (i == IDX_PEN) || (i == IDX_ADM) || (i == IDX_STA) ||
             (i == IDX_EVS) || (i == IDX_EVC) || (i == IDX_EVE);
   endfunction

endpackage

// ### logic/ifms_pin_filt.sv
// Purpose: bring bus pin levels into the aclk domain
// Assumes: lines idle high
// Notes:   a level change is accepted once stages two and three agree
module ifms_pin_filt
   import ifms_pkg::*;
#(
   parameter int W = 2
)
(
   input  wire logic         aclk,
   input  wire logic         aresetn,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);

   logic [W-1:0] s1_r;
   logic [W-1:0] s2_r;
   logic [W-1:0] s3_r;
   logic [W-1:0] q_r;
   logic [W-1:0] q_nxt;

   // stage one feeds stage two only
   always_comb
   begin
      q_nxt = (~(s2_r ^ s3_r) & s3_r) | ((s2_r ^ s3_r) & q_r);
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s1_r <= {W{PIN_IDLE}};
         s2_r <= {W{PIN_IDLE}};
         s3_r <= {W{PIN_IDLE}};
         q_r  <= {W{PIN_IDLE}};
      end
      else
      begin
         s1_r <= d;
         s2_r <= s1_r;
         s3_r <= s2_r;
         q_r  <= q_nxt;
      end
   end

   assign q = q_r;

endmodule

// ### logic/ifms_top.sv
// Purpose: start/stop detection, byte tracking and open-drain pins for a
//          firmware driven i2c master, with an axi4-lite register slave
// Assumes: pins arrive asynchronous to aclk; both lines idle high
// Notes:   slave transmit and 10-bit address match are not handled here
//
// How it works
// - reset or disable clears start/stop flags
// - start sets S clears P; stop reverse
// - enabled pin outputs always drive low
// - start, stop (master, S7I, S10I modes), byte end (master mode or addressed slave) set irq flag
// - enabled irq fires one cycle after the flag sets
// - slave acks match in slave modes only, never in master mode
// - enable bit gates bus tracking and the pin enables, not the irq output
// - mode field selects slave or master
//
// Register access over AXI4-Lite was chosen for this implementation.
module ifms_top
   import ifms_pkg::*;
(
   input  wire logic              aclk,
   input  wire logic              aresetn,
   input  wire logic [ADDR_W-1:0] awaddr,
   input  wire logic              awvalid,
   output logic                   awready,
   input  wire logic [31:0]       wdata,
   input  wire logic [3:0]        wstrb,
   input  wire logic              wvalid,
   output logic                   wready,
   output logic [1:0]             bresp,
   output logic                   bvalid,
   input  wire logic              bready,
   input  wire logic [ADDR_W-1:0] araddr,
   input  wire logic              arvalid,
   output logic                   arready,
   output logic [31:0]            rdata,
   output logic [1:0]             rresp,
   output logic                   rvalid,
   input  wire logic              rready,
   input  wire logic              scl_i,
   output logic                   scl_o,
   output logic                   scl_oe,
   input  wire logic              sda_i,
   output logic                   sda_o,
   output logic                   sda_oe,
   output logic                   irq
);

   ifms_st_t   r;
   ifms_st_t   n;
   logic       pin_lo_r;
   logic [1:0] pins_q;
   logic       scl_f;
   logic       sda_f;
   logic       start_c;
   logic       stop_c;
   logic       rise_c;
   logic       fall_c;
   logic       en;
   logic       slv;
   logic       mst;
   logic       sp_irq;

   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   ifms_pin_filt #(.W(2)) u_filt
   (
      .aclk    (aclk),
      .aresetn (aresetn),
      .d       ({scl_i, sda_i}),
      .q       (pins_q)
   );

   assign scl_f   = pins_q[1];
   assign sda_f   = pins_q[0];
   assign start_c = scl_f && r.scl_p && r.sda_p && !sda_f;
   assign stop_c  = scl_f && r.scl_p && !r.sda_p && sda_f;
   assign rise_c  = scl_f && !r.scl_p;
   assign fall_c  = !scl_f && r.scl_p;
   assign en      = r.ctl[CTL_EN];
   assign mst     = r.ctl[3:0] == MODE_MST;
   assign slv     = (r.ctl[3:0] == MODE_S7) || (r.ctl[3:0] == MODE_S10) ||
                    (r.ctl[3:0] == MODE_S7I) || (r.ctl[3:0] == MODE_S10I);
   assign sp_irq  = mst || (r.ctl[3:0] == MODE_S7I) || (r.ctl[3:0] == MODE_S10I);

   always_comb
   begin
      logic [7:0] rb;
      logic [2:0] ev;
      logic       hit;
      logic       nob;
      rb  = RST_ZERO;
      ev  = 3'h0;
      hit = 1'b0;
      nob = !r.bf && !r.ctl[CTL_OV];
      n   = r;
      n.scl_p = scl_f;
      n.sda_p = sda_f;

      // write channels are taken in either order, answered once both are held
      if (awvalid && r.awready)
      begin
         n.awh = 1'b1;
         n.awa = awaddr[ADDR_W-1:2];
      end
      if (wvalid && r.wready)
      begin
         n.wh = 1'b1;
         n.wd = wdata[7:0];
         n.ws = wstrb[0];
      end
      if (r.bvalid && bready)
      begin
         n.bvalid = 1'b0;
      end
      if (r.awh && r.wh && !r.bvalid)
      begin
         n.awh    = 1'b0;
         n.wh     = 1'b0;
         n.bvalid = 1'b1;
         n.bresp  = ifms_mapped(r.awa) ? RESP_OKAY : RESP_SLVERR;
         if (r.ws)
         begin
            case (r.awa)
               IDX_GIC: n.gic    = r.wd;
               IDX_PIF: n.pif    = r.wd;
               IDX_BUF: n.buf_q  = r.wd;
               IDX_CTL: n.ctl    = r.wd;
               IDX_DIR: n.dir    = r.wd;
               IDX_PEN: n.pen    = r.wd;
               IDX_ADM: n.adm    = r.wd;
               IDX_STA: n.sta_hi = r.wd[7:6];
               IDX_EVC: n.evs    = r.evs & ~r.wd[2:0];
               IDX_EVE: n.eve    = r.wd[2:0];
               default: n.evs    = r.evs;
            endcase
         end
      end
      n.awready = !n.awh && !n.bvalid;
      n.wready  = !n.wh && !n.bvalid;

      // read channel; reading the data buffer empties it
      if (r.rvalid && rready)
      begin
         n.rvalid = 1'b0;
      end
      if (arvalid && r.arready)
      begin
         case (araddr[ADDR_W-1:2])
            IDX_GIC: rb = r.gic;
            IDX_PIF: rb = r.pif;
            IDX_BUF: rb = r.buf_q;
            IDX_CTL: rb = r.ctl;
            IDX_DIR: rb = r.dir;
            IDX_PEN: rb = r.pen;
            IDX_ADM: rb = r.adm;
            IDX_STA: rb = {r.sta_hi, r.da, r.p, r.s, r.rw, 1'b0, r.bf};
            IDX_EVS: rb = {5'h00, r.evs};
            IDX_EVE: rb = {5'h00, r.eve};
            default: rb = RST_ZERO;
         endcase
         if (araddr[ADDR_W-1:2] == IDX_BUF)
         begin
            n.bf = 1'b0;
         end
         n.rvalid = 1'b1;
         n.rdata  = {24'h000000, rb};
         n.rresp  = ifms_mapped(araddr[ADDR_W-1:2]) ? RESP_OKAY : RESP_SLVERR;
      end
      n.arready = !n.rvalid;

      // bus tracking runs after register writes so hardware sets win
      if (!en)
      begin
         n.s    = 1'b0;
         n.p    = 1'b0;
         n.ph   = PH_IDLE;
         n.ack  = 1'b0;
         n.addr = 1'b0;
      end
      else if (start_c)
      begin
         n.s     = 1'b1;
         n.p     = 1'b0;
         n.ph    = PH_DATA;
         n.cnt   = 4'h0;
         n.first = 1'b1;
         n.ack   = 1'b0;
         ev[EV_START] = 1'b1;
      end
      else if (stop_c)
      begin
         n.s    = 1'b0;
         n.p    = 1'b1;
         n.ph   = PH_IDLE;
         n.addr = 1'b0;
         n.ack  = 1'b0;
         ev[EV_STOP] = 1'b1;
      end
      else
      begin
         case (r.ph)
            PH_DATA:
            begin
               if (rise_c && (r.cnt < BITS_PER_BYTE))
               begin
                  n.sr  = {r.sr[6:0], sda_f};
                  n.cnt = r.cnt + 4'h1;
               end
               else if (fall_c && (r.cnt == BITS_PER_BYTE))
               begin
                  n.ph = PH_ACK;
                  if (r.first)
                  begin
                     // only the slave modes match the address; master mode never does
                     hit    = slv && (r.sr[7:1] == r.adm[7:1]);
                     n.addr = hit;
                     n.rw   = r.sr[0];
                     n.da   = 1'b0;
                     n.ack  = hit && nob;
                  end
                  else
                  begin
                     hit   = mst || (r.addr && !r.rw);
                     n.da  = 1'b1;
                     n.ack = r.addr && !r.rw && nob;
                  end
                  if (hit && r.bf)
                  begin
                     n.ctl[CTL_OV] = 1'b1;
                  end
                  else if (hit)
                  begin
                     n.buf_q = r.sr;
                     n.bf    = 1'b1;
                  end
               end
            end
            PH_ACK:
            begin
               if (fall_c)
               begin
                  n.ph    = PH_DATA;
                  n.cnt   = 4'h0;
                  n.first = 1'b0;
                  n.ack   = 1'b0;
                  ev[EV_BYTE] = mst || r.addr;
               end
            end
            default:
            begin
               n.ph = PH_IDLE;
            end
         endcase
      end
      if (!slv)
      begin
         n.addr = 1'b0;
      end

      // shared flag: firmware must tell the sources apart
      if (ev[EV_BYTE] || ((ev[EV_START] || ev[EV_STOP]) && sp_irq))
      begin
         n.pif[PIF_SSP] = 1'b1;
      end
      n.evs = n.evs | ev;

      // pins are open drain: only the enable moves, the level is always low
      n.scl_oe = en && !r.dir[DIR_SCL];
      n.sda_oe = en && (!r.dir[DIR_SDA] || n.ack);
      n.irq    = (|(r.evs & r.eve)) || (r.pif[PIF_SSP] && r.pen[PIF_SSP] &&
                 r.gic[GIC_GIE] && r.gic[GIC_PEIE]);
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         r        <= ST_RST;
         pin_lo_r <= 1'b0;
      end
      else
      begin
         r        <= n;
         pin_lo_r <= 1'b0;
      end
   end

   assign awready = r.awready;
   assign wready  = r.wready;
   assign bvalid  = r.bvalid;
   assign bresp   = r.bresp;
   assign arready = r.arready;
   assign rvalid  = r.rvalid;
   assign rdata   = r.rdata;
   assign rresp   = r.rresp;
   assign scl_o   = pin_lo_r;
   assign sda_o   = pin_lo_r;
   assign scl_oe  = r.scl_oe;
   assign sda_oe  = r.sda_oe;
   assign irq     = r.irq;

   sequence s_stop_irq_on;
      en && stop_c && sp_irq && r.pen[PIF_SSP] && r.gic[GIC_GIE] && r.gic[GIC_PEIE];
   endsequence

   sequence s_flag_then_irq;
      r.pif[PIF_SSP] ##1 irq;
   endsequence

   property p_dis_clear;
      !en |=> !r.s && !r.p;
   endproperty
   a_dis_clear: assert property (p_dis_clear)
      else $error("start/stop flags not cleared while disabled");

   property p_start_flags;
      en && start_c |=> r.s && !r.p;
   endproperty
   a_start_flags: assert property (p_start_flags)
      else $error("start did not set S and clear P");

   property p_stop_flags;
      en && stop_c |=> !r.s && r.p;
   endproperty
   a_stop_flags: assert property (p_stop_flags)
      else $error("stop did not set P and clear S");

   property p_drive_low;
      !scl_o && !sda_o;
   endproperty
   a_drive_low: assert property (p_drive_low)
      else $error("pin output level not low");

   property p_scl_oe;
      en && !r.dir[DIR_SCL] |=> scl_oe;
   endproperty
   a_scl_oe: assert property (p_scl_oe)
      else $error("clock line not driven with direction output");

   property p_start_irq;
      en && start_c && sp_irq |=> r.pif[PIF_SSP];
   endproperty
   a_start_irq: assert property (p_start_irq)
      else $error("start did not set the interrupt flag");

   property p_byte_irq;
      en && !start_c && !stop_c && r.ph == PH_ACK && fall_c && mst |=> r.pif[PIF_SSP];
   endproperty
   a_byte_irq: assert property (p_byte_irq)
      else $error("completed byte did not set the interrupt flag");

   property p_stop_irq;
      s_stop_irq_on |=> s_flag_then_irq;
   endproperty
   a_stop_irq: assert property (p_stop_irq)
      else $error("stop with interrupt enabled gave no interrupt");

   property p_dis_pins;
      !en |=> !scl_oe && !sda_oe;
   endproperty
   a_dis_pins: assert property (p_dis_pins)
      else $error("pins driven while port disabled");

   property p_master_no_slave;
      mst |=> !r.addr;
   endproperty
   a_master_no_slave: assert property (p_master_no_slave)
      else $error("slave addressed while slave is idle");

   property p_ack_drive;
      n.ack && !r.ack && en |=> sda_oe [*2];
   endproperty
   a_ack_drive: assert property (p_ack_drive)
      else $error("address match did not pull the data line");

   property p_rhold;
      rvalid && !rready |=> rvalid && $stable(rdata);
   endproperty
   a_rhold: assert property (p_rhold)
      else $error("read answer dropped before rready");

endmodule

// ### test/ifms_bus_peer.sv
// Purpose: behavioural second party on the i2c lines, a master elsewhere
// Assumes: open-drain lines with pull-ups; link period 160 ns
// Notes:   the clock line stands released between frames
module ifms_bus_peer
(
   input  wire logic sda_in,
   output logic      scl_oe,
   output logic      sda_oe
);
   timeunit 1ns;
   timeprecision 1ps;

   logic lost;

   initial
   begin
      scl_oe = 1'b0;
      sda_oe = 1'b0;
      lost   = 1'b0;
   end

   // the bus is only taken after a stop or from idle
   task automatic start_cond();
      sda_oe = 1'b1;
      #80;
      scl_oe = 1'b1;
      #40;
   endtask

   task automatic stop_cond();
      sda_oe = 1'b1;
      #40;
      scl_oe = 1'b0;
      #80;
      sda_oe = 1'b0;
      #80;
   endtask

   // a one is sent by releasing the data line, a zero by pulling it;
   // a low line under a released one means another master won the bus
   task automatic send_byte(input logic [7:0] b, output logic ack);
      lost = 1'b0;
      for (int i = 7; i >= 0; i--)
      begin
         sda_oe = ~b[i] & ~lost;
         #40;
         scl_oe = 1'b0;
         #40;
         if (b[i] && !sda_in)
            lost = 1'b1;
         #40;
         scl_oe = 1'b1;
         #40;
      end
      sda_oe = 1'b0;
      // long low phase: a slave can pull only after its filtered clock fall
      #200;
      scl_oe = 1'b0;
      #60;
      ack = sda_in;
      #20;
      scl_oe = 1'b1;
      #40;
   endtask
endmodule

// ### test/tb_top.sv
// Purpose: self-checking bench for the i2c firmware master support block
// Assumes: peer model drives the far side of the bus pins
// Notes:   registers are reached over axi4-lite, byte address = 4 * index
module tb_top
   import ifms_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   typedef struct packed {
      logic [7:0] idx;
      logic [7:0] val;
      logic [1:0] resp;
   } ifms_row_t;

   localparam ifms_row_t ROWS [7] = '{'{IDX_DIR, 8'hff, RESP_OKAY},
      '{IDX_CTL, 8'h00, RESP_OKAY}, '{IDX_STA, 8'h00, RESP_OKAY},
      '{IDX_PIF, 8'h00, RESP_OKAY}, '{IDX_PEN, 8'h00, RESP_OKAY},
      '{IDX_ADM, 8'h00, RESP_OKAY}, '{8'h20, 8'h00, RESP_SLVERR}};

   logic              aclk;
   logic              aresetn;
   logic [ADDR_W-1:0] awaddr;
   logic              awvalid;
   logic              awready;
   logic [31:0]       wdata;
   logic [3:0]        wstrb;
   logic              wvalid;
   logic              wready;
   logic [1:0]        bresp;
   logic              bvalid;
   logic              bready;
   logic [ADDR_W-1:0] araddr;
   logic              arvalid;
   logic              arready;
   logic [31:0]       rdata;
   logic [1:0]        rresp;
   logic              rvalid;
   logic              rready;
   logic              scl_o;
   logic              scl_oe;
   logic              sda_o;
   logic              sda_oe;
   logic              irq;
   logic              scl_w;
   logic              sda_w;
   logic [31:0]       rd_q;
   logic [1:0]        rd_resp;
   logic [1:0]        wr_resp;
   logic              peer_scl_oe;
   logic              peer_sda_oe;
   logic              ack;
   int                n_errors;
   int                total_checks;
   int                cyc;

   ifms_bus_peer i_ifms_bus_peer
   (
      .sda_in (sda_w),
      .scl_oe (peer_scl_oe),
      .sda_oe (peer_sda_oe)
   );

   // pull-ups: a line is low while any party enables its driver
   assign scl_w = ~(scl_oe | peer_scl_oe);
   assign sda_w = ~(sda_oe | peer_sda_oe);

   ifms_top i_ifms_top (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
      .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
      .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
      .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
      .scl_i(scl_w), .scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda_w), .sda_o(sda_o),
      .sda_oe(sda_oe), .irq(irq));

   initial
   begin
      aclk = 1'b0;
      forever #10 aclk = ~aclk;
   end

   task automatic stop_test();
      if (n_errors == 0 && total_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   always @(posedge aclk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         n_errors++;
         stop_test();
      end
   end

   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      total_checks++;
      if (got !== exp)
      begin
         n_errors++;
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
      end
   endtask

   // write address and data go out together, each dropped once taken;
   // the answers are looked at mid-cycle, where they stand still
   task automatic wr(input logic [7:0] idx, input logic [7:0] d);
      logic aw_ok;
      logic w_ok;
      logic b_ok;
      @(posedge aclk);
      awaddr  <= {idx, 2'b00};
      wdata   <= {24'h0, d};
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      do
      begin
         @(negedge aclk);
         aw_ok   = awready;
         w_ok    = wready;
         b_ok    = bvalid;
         wr_resp = bresp;
         @(posedge aclk);
         if (aw_ok === 1'b1)
            awvalid <= 1'b0;
         if (w_ok === 1'b1)
            wvalid <= 1'b0;
      end while (b_ok !== 1'b1);
      bready <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] idx);
      logic ar_ok;
      logic r_ok;
      @(posedge aclk);
      araddr  <= {idx, 2'b00};
      arvalid <= 1'b1;
      rready  <= 1'b1;
      do
      begin
         @(negedge aclk);
         ar_ok   = arready;
         r_ok    = rvalid;
         rd_q    = rdata;
         rd_resp = rresp;
         @(posedge aclk);
         if (ar_ok === 1'b1)
            arvalid <= 1'b0;
      end while (r_ok !== 1'b1);
      rready <= 1'b0;
   endtask

   // ends mid-cycle so that level outputs are read while settled
   task automatic settle();
      repeat (10) @(posedge aclk);
      @(negedge aclk);
   endtask

   initial
   begin
      n_errors = 0;
      total_checks = 0;
      cyc = 0;
      aresetn = 1'b0;
      {awaddr, awvalid, wdata, wvalid, bready, araddr, arvalid, rready} = '0;
      wstrb = 4'hf;
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      foreach (ROWS[i])
      begin
         rd(ROWS[i].idx);
         chk("reg", {24'h0, ROWS[i].val}, rd_q);
         chk("resp", {30'h0, ROWS[i].resp}, {30'h0, rd_resp});
      end
      wr(8'h20, 8'h00);
      chk("bresp_bad", {30'h0, RESP_SLVERR}, {30'h0, wr_resp});
      wr(IDX_ADM, 8'h00);
      chk("bresp_ok", {30'h0, RESP_OKAY}, {30'h0, wr_resp});
      // port disabled: bus activity leaves the flags clear
      i_ifms_bus_peer.start_cond();
      settle();
      rd(IDX_STA);
      chk("sta_off", 32'h0, rd_q);
      i_ifms_bus_peer.stop_cond();
      wr(IDX_PEN, 8'h08);
      wr(IDX_GIC, 8'hc0);
      wr(IDX_CTL, 8'h2b);
      i_ifms_bus_peer.start_cond();
      settle();
      rd(IDX_STA);
      chk("sta_start", 32'h08, rd_q);
      rd(IDX_PIF);
      chk("pif_start", 32'h08, rd_q);
      chk("irq_start", 32'h1, {31'h0, irq});
      wr(IDX_PIF, 8'h00);
      settle();
      chk("irq_clr", 32'h0, {31'h0, irq});
      rd(IDX_EVS);
      chk("evs", 32'h01, rd_q);
      wr(IDX_EVE, 8'h01);
      settle();
      chk("irq_ev", 32'h1, {31'h0, irq});
      wr(IDX_EVC, 8'h01);
      settle();
      chk("irq_evc", 32'h0, {31'h0, irq});
      wr(IDX_EVE, 8'h00);
      i_ifms_bus_peer.send_byte(8'h5a, ack);
      chk("ack_idle", 32'h1, {31'h0, ack});
      settle();
      rd(IDX_PIF);
      chk("pif_byte", 32'h08, rd_q);
      wr(IDX_PIF, 8'h00);
      i_ifms_bus_peer.stop_cond();
      settle();
      rd(IDX_STA);
      chk("sta_stop", 32'h10, rd_q);
      chk("irq_stop", 32'h1, {31'h0, irq});
      wr(IDX_PIF, 8'h00);
      wr(IDX_CTL, 8'h0b);
      settle();
      rd(IDX_STA);
      chk("sta_dis", 32'h0, rd_q);
      // slave logic in 7-bit slave mode answers its own address from the peer master
      wr(IDX_ADM, 8'ha0);
      wr(IDX_CTL, 8'h26);
      i_ifms_bus_peer.start_cond();
      i_ifms_bus_peer.send_byte(8'ha0, ack);
      chk("ack_slv", 32'h0, {31'h0, ack});
      settle();
      rd(IDX_BUF);
      chk("buf", 32'ha0, rd_q);
      i_ifms_bus_peer.stop_cond();
      settle();
      wr(IDX_CTL, 8'h2b);
      wr(IDX_DIR, 8'he7);
      settle();
      chk("oe", 32'h3, {30'h0, scl_oe, sda_oe});
      chk("lvl", 32'h0, {30'h0, scl_o, sda_o});
      stop_test();
   end
endmodule
